// ==== core/rwc_pkg.sv ====
// Constants and types shared by the rheostat wiper control core.
package rwc_pkg;
   localparam int         WIPER_W       = 10;
   localparam int         TAPS          = 1024;
   localparam logic [9:0] MIDSCALE      = 10'h200;
   localparam int         FUSE_LOCS     = 50;
   localparam logic [5:0] FUSE_FIRST    = 6'h01;
   localparam logic [5:0] FUSE_NONE     = 6'h00;
   localparam logic [5:0] FUSE_FULL     = 6'h32;
   localparam int         CLK_HZ        = 100_000_000;
   localparam int         FUSE_WRITE_MS = 350;
   localparam int         FUSE_CYCLES   = FUSE_WRITE_MS * (CLK_HZ / 1000);
   localparam int         BUSY_W        = 26;
   localparam logic [6:0] DEV_ADDR      = 7'h2E;
   localparam logic [2:0] SYNC_RST      = 3'h7;
   localparam logic [3:0] CTRL_RST      = 4'h0;
   // Register map of the bus slave.
   localparam int         AXI_AW        = 4;
   localparam logic [3:0] REG_IRQ_STAT  = 4'h0;
   localparam logic [3:0] REG_IRQ_MASK  = 4'h4;
   localparam logic [3:0] REG_STATE     = 4'h8;
   localparam int         EV_W          = 4;
   localparam int         EV_FUSE_DONE  = 0;
   localparam int         EV_FUSE_REFD  = 1;
   localparam int         EV_RESET      = 2;
   localparam int         EV_SHDN       = 3;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef enum logic [3:0] {
      CMD_NOP = 4'h0, CMD_WR_WIPER = 4'h1, CMD_RD_WIPER = 4'h2,
      CMD_STORE = 4'h3, CMD_SOFT_RST = 4'h4, CMD_RD_FUSE = 4'h5,
      CMD_RD_LAST = 4'h6, CMD_WR_CTRL = 4'h7, CMD_RD_CTRL = 4'h8,
      CMD_SHUTDOWN = 4'h9
   } rwc_code_t;

   typedef struct packed {
      logic [1:0] pad;
      rwc_code_t  code;
      logic [9:0] data;
   } rwc_cmd_t;

   typedef struct packed {
      logic fuse_program_success;
      logic tolerance_cal_control;
      logic wiper_write_enable;
      logic fuse_program_enable;
   } rwc_ctrl_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ADDR_ACK = 3'h2, ST_WR = 3'h3,
      ST_WR_ACK = 3'h4, ST_RD = 3'h5, ST_RD_ACK = 3'h6
   } rwc_i2c_st_t;
endpackage

// ==== core/rwc_core.sv ====
// Serial command core of a single-channel digital rheostat.
`timescale 1ns/100ps
module rwc_core #(
   parameter int FUSE_CYCLES_P = rwc_pkg::FUSE_CYCLES
) (
   input  wire logic                  aclk,          // System clock
   input  wire logic                  aresetn,       // Sync reset, low
   input  wire logic                  scl_i,         // Serial clock pin
   input  wire logic                  sda_i,         // Serial data in
   output wire logic                  sda_o,         // Serial data out
   output logic                       sda_oe_n,      // Data enable, low
   input  wire logic                  reset_pin_n,   // Reset pin, low
   output logic [rwc_pkg::TAPS-1:0]   tap_sel,       // One-hot tap
   output logic                       term_a_open,   // Terminal A off
   output logic                       tol_cal_en,    // Calibration on
   output wire logic                  irq,           // Interrupt level
   input  wire logic [3:0]            s_axi_awaddr,  // Write address
   input  wire logic                  s_axi_awvalid, // Write addr valid
   output wire logic                  s_axi_awready, // Write addr ready
   input  wire logic [31:0]           s_axi_wdata,   // Write data
   input  wire logic [3:0]            s_axi_wstrb,   // Write strobes
   input  wire logic                  s_axi_wvalid,  // Write data valid
   output wire logic                  s_axi_wready,  // Write data ready
   output logic [1:0]                 s_axi_bresp,   // Write response
   output logic                       s_axi_bvalid,  // Response valid
   input  wire logic                  s_axi_bready,  // Response ready
   input  wire logic [3:0]            s_axi_araddr,  // Read address
   input  wire logic                  s_axi_arvalid, // Read addr valid
   output wire logic                  s_axi_arready, // Read addr ready
   output logic [31:0]                s_axi_rdata,   // Read data
   output logic [1:0]                 s_axi_rresp,   // Read response
   output logic                       s_axi_rvalid,  // Read data valid
   input  wire logic                  s_axi_rready   // Read data ready
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_d_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg  <= rwc_pkg::SYNC_RST;
         sync2_reg  <= rwc_pkg::SYNC_RST;
         sync3_reg  <= rwc_pkg::SYNC_RST;
         filt_reg   <= rwc_pkg::SYNC_RST;
         filt_d_reg <= rwc_pkg::SYNC_RST;
      end else begin
         sync1_reg  <= {reset_pin_n, sda_i, scl_i};
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         filt_d_reg <= filt_reg;
         for (int i = 0; i < 3; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
               filt_reg[i] <= sync3_reg[i];
            end
         end
      end
   end

   logic scl_f, sda_f, scl_rise, scl_fall, start_ev, stop_ev, hw_rst_ev;
   assign scl_f     = filt_reg[0];
   assign sda_f     = filt_reg[1];
   assign scl_rise  = scl_f & ~filt_d_reg[0];
   assign scl_fall  = ~scl_f & filt_d_reg[0];
   assign start_ev  = scl_f & filt_d_reg[0] & ~sda_f & filt_d_reg[1];
   assign stop_ev   = scl_f & filt_d_reg[0] & sda_f & ~filt_d_reg[1];
   assign hw_rst_ev = ~filt_reg[2] & filt_d_reg[2];
   assign sda_o     = 1'b0;

   // ----------------------------------------------------------------
   // Serial slave
   // ----------------------------------------------------------------
   rwc_pkg::rwc_i2c_st_t st_reg;
   rwc_pkg::rwc_cmd_t    cmd_reg;
   logic [2:0]  cnt_reg;
   logic [7:0]  sh_reg, tx_reg, hi_reg, nxt_byte;
   logic        full_reg, rw_reg, mack_reg, bidx_reg, cmd_vld_reg;
   logic        busy;
   logic [15:0] rd_word_reg;

   assign nxt_byte = bidx_reg ? rd_word_reg[15:8] : rd_word_reg[7:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg      <= rwc_pkg::ST_IDLE;
         cnt_reg     <= 3'h0;
         sh_reg      <= 8'h00;
         tx_reg      <= 8'h00;
         hi_reg      <= 8'h00;
         full_reg    <= 1'b0;
         rw_reg      <= 1'b0;
         mack_reg    <= 1'b0;
         bidx_reg    <= 1'b0;
         sda_oe_n    <= 1'b1;
         cmd_vld_reg <= 1'b0;
         cmd_reg     <= '0;
      end else begin
         cmd_vld_reg <= 1'b0;
         if (start_ev) begin
            st_reg   <= rwc_pkg::ST_ADDR;
            cnt_reg  <= 3'h0;
            full_reg <= 1'b0;
            bidx_reg <= 1'b0;
            sda_oe_n <= 1'b1;
         end else if (stop_ev) begin
            st_reg   <= rwc_pkg::ST_IDLE;
            sda_oe_n <= 1'b1;
         end else if (scl_rise) begin
            case (st_reg)
               rwc_pkg::ST_ADDR, rwc_pkg::ST_WR, rwc_pkg::ST_RD: begin
                  sh_reg   <= {sh_reg[6:0], sda_f};
                  cnt_reg  <= cnt_reg + 3'h1;
                  full_reg <= (cnt_reg == 3'h7);
               end
               rwc_pkg::ST_RD_ACK: mack_reg <= ~sda_f;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (st_reg)
               rwc_pkg::ST_ADDR: if (full_reg) begin
                  full_reg <= 1'b0;
                  if (sh_reg[7:1] == rwc_pkg::DEV_ADDR && !busy) begin
                     st_reg   <= rwc_pkg::ST_ADDR_ACK;
                     sda_oe_n <= 1'b0;
                     rw_reg   <= sh_reg[0];
                  end else begin
                     st_reg <= rwc_pkg::ST_IDLE;
                  end
               end
               rwc_pkg::ST_ADDR_ACK: begin
                  bidx_reg <= 1'b0;
                  if (rw_reg) begin
                     st_reg   <= rwc_pkg::ST_RD;
                     tx_reg   <= rd_word_reg[15:8];
                     sda_oe_n <= rd_word_reg[15];
                  end else begin
                     st_reg   <= rwc_pkg::ST_WR;
                     sda_oe_n <= 1'b1;
                  end
               end
               rwc_pkg::ST_WR: if (full_reg) begin
                  full_reg <= 1'b0;
                  sda_oe_n <= 1'b0;
                  st_reg   <= rwc_pkg::ST_WR_ACK;
                  bidx_reg <= ~bidx_reg;
                  if (!bidx_reg) begin
                     hi_reg <= sh_reg;
                  end else begin
                     cmd_vld_reg <= 1'b1;
                     cmd_reg     <= {hi_reg, sh_reg};
                  end
               end
               rwc_pkg::ST_WR_ACK: begin
                  sda_oe_n <= 1'b1;
                  st_reg   <= rwc_pkg::ST_WR;
               end
               rwc_pkg::ST_RD: if (full_reg) begin
                  full_reg <= 1'b0;
                  sda_oe_n <= 1'b1;
                  st_reg   <= rwc_pkg::ST_RD_ACK;
               end else begin
                  tx_reg   <= {tx_reg[6:0], 1'b0};
                  sda_oe_n <= tx_reg[6];
               end
               rwc_pkg::ST_RD_ACK: if (mack_reg) begin
                  st_reg   <= rwc_pkg::ST_RD;
                  bidx_reg <= ~bidx_reg;
                  tx_reg   <= nxt_byte;
                  sda_oe_n <= nxt_byte[7];
               end else begin
                  st_reg <= rwc_pkg::ST_IDLE;
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Command execution
   // ----------------------------------------------------------------
   rwc_pkg::rwc_ctrl_t ctrl_reg;
   logic [9:0]  wiper_code_register;
   logic [9:0]  fuse_memory [1:rwc_pkg::FUSE_LOCS];
   logic [5:0]  last_loc_reg;
   logic [rwc_pkg::BUSY_W-1:0] busy_cnt_reg;
   logic        shdn_reg, reload_pend_reg;
   logic        is_cmd [16];
   logic        rst_ev, store_ok, store_refd, fuse_done;
   logic [9:0]  reload_val;

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         is_cmd[i] = cmd_vld_reg && (cmd_reg.code == 4'(i));
      end
   end

   assign rst_ev     = is_cmd[rwc_pkg::CMD_SOFT_RST] | hw_rst_ev
                       | reload_pend_reg;
   assign reload_val = (last_loc_reg == rwc_pkg::FUSE_NONE) ?
                       rwc_pkg::MIDSCALE : fuse_memory[last_loc_reg];
   assign store_ok   = is_cmd[rwc_pkg::CMD_STORE]
                       && ctrl_reg.fuse_program_enable
                       && last_loc_reg != rwc_pkg::FUSE_FULL;
   assign store_refd = is_cmd[rwc_pkg::CMD_STORE] & ~store_ok;
   assign busy       = (busy_cnt_reg != '0);
   assign fuse_done  = (busy_cnt_reg == rwc_pkg::BUSY_W'(1));

   // Power-up leaves midscale for one cycle before the fuse restore.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wiper_code_register <= rwc_pkg::MIDSCALE;
         reload_pend_reg     <= 1'b1;
      end else begin
         reload_pend_reg <= 1'b0;
         if (rst_ev) begin
            wiper_code_register <= reload_val;
         end else if (is_cmd[rwc_pkg::CMD_WR_WIPER]
                      && ctrl_reg.wiper_write_enable) begin
            wiper_code_register <= cmd_reg.data;
         end
      end
   end

   // Fuse slots are not cleared by reset: they stand for nonvolatile cells.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_loc_reg <= rwc_pkg::FUSE_NONE;
         busy_cnt_reg <= '0;
      end else begin
         if (store_ok) begin
            fuse_memory[last_loc_reg + rwc_pkg::FUSE_FIRST]
               <= wiper_code_register;
            last_loc_reg <= last_loc_reg + rwc_pkg::FUSE_FIRST;
            busy_cnt_reg <= rwc_pkg::BUSY_W'(FUSE_CYCLES_P);
         end else if (busy) begin
            busy_cnt_reg <= busy_cnt_reg - rwc_pkg::BUSY_W'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= rwc_pkg::CTRL_RST;
      end else begin
         // calibration bit written with both enables
         if (is_cmd[rwc_pkg::CMD_WR_CTRL]) begin
            ctrl_reg.fuse_program_enable   <= cmd_reg.data[0];
            ctrl_reg.wiper_write_enable    <= cmd_reg.data[1];
            ctrl_reg.tolerance_cal_control <= cmd_reg.data[2];
         end
         if (fuse_done) begin
            ctrl_reg.fuse_program_success <= 1'b1;
         end else if (store_ok | store_refd) begin
            ctrl_reg.fuse_program_success <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shdn_reg    <= 1'b0;
         rd_word_reg <= 16'h0000;
      end else begin
         if (rst_ev) begin
            shdn_reg <= 1'b0;
         end else if (is_cmd[rwc_pkg::CMD_SHUTDOWN]) begin
            shdn_reg <= cmd_reg.data[0];
         end
         if (is_cmd[rwc_pkg::CMD_RD_WIPER]) begin
            rd_word_reg <= {6'h00, wiper_code_register};
         end else if (is_cmd[rwc_pkg::CMD_RD_FUSE]) begin
            rd_word_reg <= (cmd_reg.data[5:0] == rwc_pkg::FUSE_NONE ||
                            cmd_reg.data[5:0] > last_loc_reg) ? 16'h0000 :
                           {6'h00, fuse_memory[cmd_reg.data[5:0]]};
         end else if (is_cmd[rwc_pkg::CMD_RD_LAST]) begin
            rd_word_reg <= {10'h000, last_loc_reg};
         end else if (is_cmd[rwc_pkg::CMD_RD_CTRL]) begin
            rd_word_reg <= {12'h000, ctrl_reg};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         term_a_open <= 1'b0;
         tol_cal_en  <= 1'b1;
      end else begin
         term_a_open <= shdn_reg;
         tol_cal_en  <= ~ctrl_reg.tolerance_cal_control;
      end
   end

   for (genvar t = 0; t < rwc_pkg::TAPS; t++) begin : g_tap
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            tap_sel[t] <= (rwc_pkg::MIDSCALE == 10'(t));
         end else begin
            tap_sel[t] <= (wiper_code_register == 10'(t));
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus slave and interrupts
   // ----------------------------------------------------------------
   logic [3:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic        aw_hold_reg, w_hold_reg, wstrb0_reg, wr_do;
   logic [rwc_pkg::EV_W-1:0] irq_stat_reg, irq_mask_reg, ev, clr;
   logic [31:0] rd_mux;

   assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_do         = aw_hold_reg & w_hold_reg;
   assign irq           = |(irq_stat_reg & irq_mask_reg);
   assign ev  = {is_cmd[rwc_pkg::CMD_SHUTDOWN] & (shdn_reg != cmd_reg.data[0]),
                 rst_ev, store_refd, fuse_done};
   assign clr = (wr_do && wstrb0_reg && awaddr_reg == rwc_pkg::REG_IRQ_STAT)
                ? wdata_reg[rwc_pkg::EV_W-1:0] : '0;

   always_comb begin
      case ({s_axi_araddr[3:2], 2'b00})
         rwc_pkg::REG_IRQ_STAT: rd_mux = {28'h0, irq_stat_reg};
         rwc_pkg::REG_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg};
         rwc_pkg::REG_STATE:    rd_mux = {10'h000, last_loc_reg, busy,
                                          shdn_reg, ctrl_reg,
                                          wiper_code_register};
         default:               rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg  <= 1'b0;
         w_hold_reg   <= 1'b0;
         awaddr_reg   <= 4'h0;
         wdata_reg    <= 32'h0000_0000;
         wstrb0_reg   <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rwc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= {s_axi_awaddr[3:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (wr_do) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg == rwc_pkg::REG_IRQ_STAT ||
                             awaddr_reg == rwc_pkg::REG_IRQ_MASK ||
                             awaddr_reg == rwc_pkg::REG_STATE) ?
                            rwc_pkg::RESP_OKAY : rwc_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= rwc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= (s_axi_araddr[3:2] == 2'h3) ?
                         rwc_pkg::RESP_SLVERR : rwc_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // A new event wins over a clear landing in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
         if (wr_do && wstrb0_reg && awaddr_reg == rwc_pkg::REG_IRQ_MASK) begin
            irq_mask_reg <= wdata_reg[rwc_pkg::EV_W-1:0];
         end
      end
   end
endmodule

// ==== test/rwc_i2c_master.sv ====
// Serial bus controller model that sends commands to the rheostat core.
`timescale 1ns/100ps
module rwc_i2c_master (
   input  wire logic aclk,  // Pacing clock
   input  wire logic sda,   // Resolved data line
   output logic      scl,   // Serial clock, idles high
   output logic      sda_m  // Data drive, low pulls the line
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // A bit lasts eight clocks, 80 ns. The low phase gets six of them because
   // the core answers five clocks after the clock falls at its pin.
   task automatic step(input logic c, input logic d, input int n);
      scl <= c;
      sda_m <= d;
      repeat (n) @(posedge aclk);
   endtask
   // Data moves only while the clock is low, so no false start or stop.
   task automatic xbit(input logic b, output logic r);
      step(1'b0, sda_m, 3);
      step(1'b0, b, 3);
      step(1'b1, b, 1);
      r = sda;
      step(1'b1, b, 1);
   endtask
   task automatic xbyte(input logic [7:0] d, input logic last,
                        output logic [7:0] r, output logic ack_n);
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
      xbit(last, ack_n);
   endtask
   task automatic frame_start;
      step(scl, 1'b1, 2);
      step(1'b1, 1'b1, 2);
      step(1'b1, 1'b0, 2);
      step(1'b0, 1'b0, 2);
   endtask
   task automatic frame_stop;
      step(1'b0, 1'b0, 2);
      step(1'b1, 1'b0, 2);
      step(1'b1, 1'b1, 2);
   endtask
   // an address-only frame polls; a full one sends the word.
   task automatic cmd(input logic [15:0] w, input logic full,
                      output logic ok);
      logic [7:0] r;
      logic       a;
      frame_start;
      xbyte({rwc_pkg::DEV_ADDR, 1'b0}, 1'b1, r, a);
      ok = !a;
      if (full) xbyte(w[15:8], 1'b1, r, a);
      if (full) xbyte(w[7:0], 1'b1, r, a);
      frame_stop;
   endtask
   task automatic fetch(output logic [15:0] w);
      logic [7:0] r;
      logic       a;
      frame_start;
      xbyte({rwc_pkg::DEV_ADDR, 1'b1}, 1'b1, r, a);
      xbyte(8'hFF, 1'b0, w[15:8], a);
      xbyte(8'hFF, 1'b1, w[7:0], a);
      frame_stop;
   endtask
endmodule

// ==== test/rwc_core_sva.sv ====
// Port assertions for the rheostat wiper control core.
`timescale 1ns/100ps
module rwc_core_sva (
   input wire logic                     aclk,          // Clock
   input wire logic                     aresetn,       // Reset, low
   input wire logic                     reset_pin_n,   // Reset pin
   input wire logic [rwc_pkg::TAPS-1:0] tap_sel,       // Tap select
   input wire logic                     term_a_open,   // Terminal A off
   input wire logic                     tol_cal_en,    // Calibration on
   input wire logic                     irq,           // Interrupt
   input wire logic                     s_axi_awready, // AW ready
   input wire logic                     s_axi_wready,  // W ready
   input wire logic                     s_axi_bvalid,  // B valid
   input wire logic [3:0]               s_axi_araddr,  // AR address
   input wire logic                     s_axi_arvalid, // AR valid
   input wire logic                     s_axi_arready, // AR ready
   input wire logic [31:0]              s_axi_rdata,   // R data
   input wire logic [1:0]               s_axi_rresp,   // R response
   input wire logic                     s_axi_rvalid,  // R valid
   input wire logic                     s_axi_rready   // R ready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_reset_outputs: assert property (
      $rose(aresetn) |-> tap_sel[rwc_pkg::MIDSCALE] && !term_a_open
         && tol_cal_en && !irq)
      else $error("outputs wrong after reset");
   chk_tap_onehot: assert property ($onehot(tap_sel))
      else $error("tap select not one-hot");
   chk_pin_leaves: assert property (
      $fell(reset_pin_n) |-> ##[1:8] !term_a_open)
      else $error("shutdown kept after reset pin");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_read_holds: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_read_unmapped: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC |=>
         s_axi_rresp == rwc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answering");
   chk_write_refused: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
endmodule
bind rwc_core rwc_core_sva u_rwc_core_sva (
   .aclk, .aresetn, .reset_pin_n, .tap_sel, .term_a_open, .tol_cal_en,
   .irq, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready
);

// ==== test/tb_rwc_core.sv ====
// Self-checking bench for the rheostat wiper control core.
`timescale 1ns/100ps
module tb_rwc_core;
   // A short write cycle still outlasts one address probe on the link.
   localparam int FUSE_SIM = 2000;
   logic                     aclk = 1'b0;
   logic                     aresetn, reset_pin_n, scl, sda_m, ok;
   logic                     s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic                     s_axi_arvalid, s_axi_rready, s_axi_rvalid;
   logic                     s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic                     s_axi_arready, sda_o, sda_oe_n, irq;
   logic                     term_a_open, tol_cal_en;
   logic [3:0]               s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [1:0]               s_axi_bresp, s_axi_rresp;
   logic [31:0]              s_axi_wdata, s_axi_rdata;
   logic [rwc_pkg::TAPS-1:0] tap_sel;
   logic [15:0]              w;
   int                       errors = 0;
   int                       num_checks = 0;
   wire                      sda = sda_m & (sda_oe_n | sda_o);
   rwc_core #(.FUSE_CYCLES_P(FUSE_SIM)) u_rwc_core (
      .aclk, .aresetn, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n,
      .reset_pin_n, .tap_sel, .term_a_open, .tol_cal_en, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready
   );
   rwc_i2c_master u_rwc_i2c_master (.aclk, .sda, .scl, .sda_m);
   always #5 aclk = ~aclk;
   task automatic end_sim;
      if (errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   // One register access; d is write data, or the expected read data.
   task automatic axi(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      logic        ka, kw, kb;
      logic [31:0] g;
      logic [1:0]  r;
      @(posedge aclk);
      kb = 1'b0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      for (int n = 0; n < 50 && !kb; n++) begin
         @(negedge aclk);
         ka = wr ? s_axi_awready & s_axi_awvalid
                 : s_axi_arready & s_axi_arvalid;
         kw = s_axi_wready & s_axi_wvalid;
         kb = wr ? s_axi_bvalid : s_axi_rvalid & s_axi_rready;
         {r, g} = wr ? {s_axi_bresp, d} : {s_axi_rresp, s_axi_rdata};
         @(posedge aclk);
         if (ka) s_axi_awvalid <= 1'b0;
         if (ka) s_axi_arvalid <= 1'b0;
         if (ka) s_axi_rready <= !wr;
         if (kw) s_axi_wvalid <= 1'b0;
         if (kb) s_axi_bready <= 1'b0;
         if (kb) s_axi_rready <= 1'b0;
      end
      if (!kb) errors++;
      if (!kb) end_sim;
      if (!wr) chk(g, d);
      chk(r, a == 4'hC ? rwc_pkg::RESP_SLVERR : rwc_pkg::RESP_OKAY);
   endtask
   task automatic c(input logic [3:0] k, input logic [9:0] d);
      logic a;
      u_rwc_i2c_master.cmd({2'b00, k, d}, 1'b1, a);
      chk(a, 1'b1);
      repeat (4) @(posedge aclk);
   endtask
   initial begin
      aresetn = 1'b0;
      reset_pin_n = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00F;
      s_axi_wdata = 32'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axi(0, 4'h8, 32'h0000_0200);
      axi(0, 4'h0, 32'h0000_0004);
      chk(tol_cal_en, 1'b1);
      c(4'h1, 10'h155);
      axi(0, 4'h8, 32'h0000_0200);
      c(4'h3, 10'h000);
      axi(0, 4'h0, 32'h0000_0006);
      chk(irq, 1'b0);
      axi(1, 4'h0, 32'h0000_0006);
      axi(0, 4'h0, 32'h0);
      c(4'h7, 10'h003);
      c(4'h1, 10'h155);
      chk(tap_sel[10'h155], 1'b1);
      axi(1, 4'h4, 32'h1);
      axi(0, 4'h4, 32'h1);
      c(4'h3, 10'h000);
      u_rwc_i2c_master.cmd(16'h0, 1'b0, ok);
      chk(ok, 1'b0);
      for (int n = 0; n < 40 && !ok; n++)
         u_rwc_i2c_master.cmd(16'h0, 1'b0, ok);
      chk(ok, 1'b1);
      if (ok !== 1'b1) end_sim;
      chk(irq, 1'b1);
      axi(0, 4'h8, 32'h0001_2D55);
      axi(1, 4'h0, 32'h1);
      chk(irq, 1'b0);
      c(4'h8, 10'h000);
      u_rwc_i2c_master.fetch(w);
      chk(w[3:0], 4'hB);
      c(4'h5, 10'h001);
      u_rwc_i2c_master.fetch(w);
      chk(w[9:0], 10'h155);
      c(4'h6, 10'h000);
      u_rwc_i2c_master.fetch(w);
      chk(w[5:0], 6'h01);
      c(4'h9, 10'h001);
      chk(term_a_open, 1'b1);
      c(4'h1, 10'h0AA);
      axi(0, 4'h8, 32'h0001_6CAA);
      c(4'h2, 10'h000);
      u_rwc_i2c_master.fetch(w);
      chk(w[9:0], 10'h0AA);
      c(4'h4, 10'h000);
      axi(0, 4'h8, 32'h0001_2D55);
      c(4'h9, 10'h001);
      c(4'h9, 10'h000);
      chk(term_a_open, 1'b0);
      c(4'h9, 10'h001);
      c(4'h1, 10'h0AA);
      reset_pin_n <= 1'b0;
      repeat (8) @(posedge aclk);
      reset_pin_n <= 1'b1;
      repeat (8) @(posedge aclk);
      axi(0, 4'h8, 32'h0001_2D55);
      c(4'h7, 10'h007);
      chk(tol_cal_en, 1'b0);
      axi(1, 4'hC, 32'h1);
      axi(0, 4'hC, 32'h0);
      end_sim;
   end
endmodule
